// ---- hdl/irt_pkg.sv ----
`default_nettype none
package irt_pkg;
  // core clock rate, the only clock inside this block
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLK_NS  = 1000 / CLK_MHZ;

  // ratios of the slower clocks to the core clock, in core cycles per cycle
  localparam int unsigned BUS_DIV = 2;
  localparam int unsigned PER_DIV = 2;

  // decision delays in half core cycles per source class
  localparam int unsigned HALF_NMI  = 1 + BUS_DIV + PER_DIV;
  localparam int unsigned HALF_IRQ  = 1 + 2 * BUS_DIV + 9 * PER_DIV;
  localparam int unsigned HALF_IRQS = 1 + 2 * BUS_DIV + 5 * PER_DIV;
  localparam int unsigned HALF_PORT_INTERRUPT = HALF_IRQS;
  localparam int unsigned HALF_PA   = 1 + 3 * PER_DIV;
  localparam int unsigned HALF_PB   = 1 + 6 * PER_DIV;

  // a least time rounds up to whole core cycles
  localparam logic [4:0] DEC_NMI  = 5'((HALF_NMI + 1) / 2);
  localparam logic [4:0] DEC_IRQ  = 5'((HALF_IRQ + 1) / 2);
  localparam logic [4:0] DEC_IRQS = 5'((HALF_IRQS + 1) / 2);
  localparam logic [4:0] DEC_PORT_INTERRUPT = 5'((HALF_PORT_INTERRUPT + 1) / 2);
  localparam logic [4:0] DEC_PA   = 5'((HALF_PA + 1) / 2);
  localparam logic [4:0] DEC_PB   = 5'((HALF_PB + 1) / 2);

  // save to handler fetch, and the longest instruction on a cache hit
  localparam logic [4:0] SAVE_CYC     = 5'h05;
  localparam logic [4:0] LONGEST_HIT  = 5'h07;
  localparam logic [31:0] HANDLER_OFS = 32'h00000600;
  localparam logic [3:0]  LVL_NMI     = 4'hF;

  localparam int unsigned NSRC = 5;
  localparam int unsigned S_NMI = 0;
  localparam int unsigned S_IRQ = 1;
  localparam int unsigned S_PORT_INTERRUPT = 2;
  localparam int unsigned S_PA = 3;
  localparam int unsigned S_PB = 4;

  typedef enum logic [3:0] {
    IRT_IDLE   = 4'h1,
    IRT_DECIDE = 4'h2,
    IRT_WAIT   = 4'h4,
    IRT_SAVE   = 4'h8
  } irt_state_e;
endpackage
`default_nettype wire

// ---- hdl/irt_resp.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - hold off handling while block flag set
// - nmi and external lines decision delays
// - timer group decision: half plus 1.5 peripheral
// - dma group decision: half plus three peripheral
// - wait for current instruction boundary
// - masking next instruction defers acceptance further
// - handler fetch five cycles after save
// - longest instruction is seven cycles plus memory
// - forward only if level above mask
// - handler address is vector base plus 0x600
module irt_resp (
  input  wire logic                 MCLK,
  input  wire logic                 SYS_RST,
  input  wire logic [irt_pkg::NSRC-1:0] REQ,
  input  wire logic [3:0]           LVL_IRQ,
  input  wire logic [3:0]           LVL_PORT_INTERRUPT,
  input  wire logic [3:0]           LVL_PA,
  input  wire logic [3:0]           LVL_PB,
  input  wire logic                 IRQ_SHORT,
  input  wire logic [3:0]           INTERRUPT_MASK_LEVEL,
  input  wire logic                 EXCEPTION_BLOCK_FLAG,
  input  wire logic                 INSN_END,
  input  wire logic                 NEXT_MASKS,
  input  wire logic [31:0]          VECTOR_BASE,
  output logic                      SAVE_CTX,
  output logic                      FETCH_START,
  output logic [31:0]               HANDLER_ADDR,
  output logic                      BUSY
);
  import irt_pkg::*;

  // pin requests cross in from other clocks: two flops before any use
  logic [NSRC-1:0] sync1_reg;
  logic [NSRC-1:0] sync2_reg;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= REQ;
      sync2_reg <= sync1_reg;
    end
  end

  // per source levels; nmi always at the top level
  logic [3:0] lvl [NSRC];
  logic [4:0] dly [NSRC];
  always_comb begin
    lvl[S_NMI]  = LVL_NMI;
    lvl[S_IRQ]  = LVL_IRQ;
    lvl[S_PORT_INTERRUPT] = LVL_PORT_INTERRUPT;
    lvl[S_PA]   = LVL_PA;
    lvl[S_PB]   = LVL_PB;
    dly[S_NMI]  = DEC_NMI;
    dly[S_IRQ]  = IRQ_SHORT ? DEC_IRQS : DEC_IRQ;
    dly[S_PORT_INTERRUPT] = DEC_PORT_INTERRUPT;
    dly[S_PA]   = DEC_PA;
    dly[S_PB]   = DEC_PB;
  end

  // pick the highest pending level; lower index wins a tie
  logic [3:0] best_lvl;
  logic [2:0] best_idx;
  logic       any_req;
  always_comb begin
    best_lvl = 4'h0;
    best_idx = 3'h0;
    any_req  = 1'b0;
    for (int i = int'(NSRC) - 1; i >= 0; i--) begin
      if (sync2_reg[i] && (!any_req || lvl[i] >= best_lvl)) begin
        best_lvl = lvl[i];
        best_idx = 3'(i);
        any_req  = 1'b1;
      end
    end
  end
  // the nmi passes the mask for any mask value below 15, its own level
  logic passes;
  assign passes = any_req && (best_lvl > INTERRUPT_MASK_LEVEL);

  irt_state_e state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [2:0] src_reg, src_next;
  logic       save_reg, save_next;
  logic       fetch_reg, fetch_next;
  logic [31:0] addr_reg, addr_next;
  logic       busy_reg, busy_next;

  // sequencing: decide, wait for boundary, save, then fetch
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    src_next   = src_reg;
    save_next  = 1'b0;
    fetch_next = 1'b0;
    addr_next  = addr_reg;
    unique case (state_reg)
      IRT_IDLE: begin
        if (passes) begin
          state_next = IRT_DECIDE;
          src_next   = best_idx;
          cnt_next   = dly[best_idx] - 5'h01;
        end
      end
      IRT_DECIDE: begin
        // a request that vanishes or gets masked is dropped, not latched
        if (!passes) begin
          state_next = IRT_IDLE;
        end else if (cnt_reg == 5'h00) begin
          state_next = IRT_WAIT;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      IRT_WAIT: begin
        // accept only at a boundary, unblocked, and not deferred
        if (!passes) begin
          state_next = IRT_IDLE;
        end else if (INSN_END && !EXCEPTION_BLOCK_FLAG && !NEXT_MASKS) begin
          state_next = IRT_SAVE;
          save_next  = 1'b1;
          cnt_next   = SAVE_CYC - 5'h01;
          addr_next  = VECTOR_BASE + HANDLER_OFS;
        end
      end
      IRT_SAVE: begin
        if (cnt_reg == 5'h00) begin
          state_next = IRT_IDLE;
          fetch_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      default: state_next = IRT_IDLE;
    endcase
    // busy tracks the next state so the pin lines up with the save and fetch pulses
    busy_next = (state_next != IRT_IDLE);
  end

  // register stage for the sequencer
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= IRT_IDLE;
      cnt_reg   <= 5'h00;
      src_reg   <= 3'h0;
      save_reg  <= 1'b0;
      fetch_reg <= 1'b0;
      addr_reg  <= 32'h00000000;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      src_reg   <= src_next;
      save_reg  <= save_next;
      fetch_reg <= fetch_next;
      addr_reg  <= addr_next;
      busy_reg  <= busy_next;
    end
  end

  // every pin from its own flop; a decoded busy could glitch between states
  assign SAVE_CTX     = save_reg;
  assign FETCH_START  = fetch_reg;
  assign HANDLER_ADDR = addr_reg;
  assign BUSY         = busy_reg;

  // fetch follows the save pulse after exactly five cycles
  AST_SAVE_TO_FETCH: assert property (@(posedge MCLK) disable iff (SYS_RST)
    $rose(save_reg) |-> ##5 fetch_reg)
    else $error("fetch not five cycles after save");

  // no save while the block flag was set in the accepting cycle
  AST_BLOCK_HOLD: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_reg == IRT_WAIT && EXCEPTION_BLOCK_FLAG) |=> !save_reg)
    else $error("save taken while blocked");

  // save only at an instruction boundary
  AST_BOUNDARY: assert property (@(posedge MCLK) disable iff (SYS_RST)
    save_reg |-> $past(INSN_END))
    else $error("save away from boundary");

  // deferral by a masking next instruction
  AST_DEFER: assert property (@(posedge MCLK) disable iff (SYS_RST)
    save_reg |-> !$past(NEXT_MASKS))
    else $error("save despite deferral");

  // a save needs a level above the mask
  AST_MASK: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_reg == IRT_IDLE && any_req && best_lvl <= INTERRUPT_MASK_LEVEL) |=>
      state_reg == IRT_IDLE)
    else $error("masked request taken");

  // handler address formed from vector base
  AST_VECTOR: assert property (@(posedge MCLK) disable iff (SYS_RST)
    save_reg |-> addr_reg == $past(VECTOR_BASE) + HANDLER_OFS)
    else $error("handler address wrong");

  // nmi decision lasts its rounded delay before waiting
  AST_NMI_DELAY: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_reg == IRT_WAIT && $past(state_reg) == IRT_DECIDE && src_reg == 3'(S_NMI)) |->
      ($past(state_reg, 3) == IRT_DECIDE && $past(state_reg, 4) == IRT_IDLE))
    else $error("nmi decision length wrong");

  // timer group decision spans four cycles; a dropped request never reaches wait
  AST_PA_DELAY: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_reg == IRT_WAIT && $past(state_reg) == IRT_DECIDE && src_reg == 3'(S_PA)) |->
      ($past(state_reg, 4) == IRT_DECIDE && $past(state_reg, 5) == IRT_IDLE))
    else $error("timer group decision length wrong");

  // dma group decision spans seven cycles
  AST_PB_DELAY: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_reg == IRT_WAIT && $past(state_reg) == IRT_DECIDE && src_reg == 3'(S_PB)) |->
      ($past(state_reg, 7) == IRT_DECIDE && $past(state_reg, 8) == IRT_IDLE))
    else $error("dma group decision length wrong");

  // the wait ends at an unblocked, undeferred boundary, however long the instruction is
  AST_LONGEST: assert property (@(posedge MCLK) disable iff (SYS_RST)
    (state_reg == IRT_WAIT && passes && INSN_END && !EXCEPTION_BLOCK_FLAG && !NEXT_MASKS)
      |=> save_reg)
    else $error("boundary passed without acceptance");
endmodule
`default_nettype wire

// ---- tb/irt_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module irt_cpu_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] insn_len,
  input  wire logic       blk_in,
  input  wire logic       masks_in,
  output logic            insn_end,
  output logic            blk_flag,
  output logic            next_masks
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  // state counter of the running instruction, length set by the bench
  always_comb cnt_next = (cnt_reg >= insn_len - 3'h1) ? 3'h0 : cnt_reg + 3'h1;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) cnt_reg <= 3'h0;
    else cnt_reg <= cnt_next;
  end
  // boundary on the last state; a length of one ends every cycle
  assign insn_end = (cnt_reg >= insn_len - 3'h1);
  // flags pass straight through; the bench plays the clearing instruction
  assign blk_flag = blk_in;
  assign next_masks = masks_in;
endmodule
`default_nettype wire

// ---- tb/irt_resp_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module irt_resp_tb;
  import irt_pkg::*;
  typedef struct {int lo; int hi; logic [31:0] a;} irt_note_s;
  logic mclk, rst, sh, blk, msk, ie, bf, nm, save, fetch, busy;
  logic [NSRC-1:0] req;
  logic [3:0] lv, mask;
  logic [2:0] len;
  logic [31:0] vb, addr;
  logic [15:0] lf = 16'h794B;
  int cyc, fexp, num_errors, checks_done;
  irt_note_s q[$];
  irt_note_s n;
  irt_resp dut_u (.MCLK(mclk), .SYS_RST(rst), .REQ(req), .LVL_IRQ(lv), .LVL_PORT_INTERRUPT(lv),
    .LVL_PA(lv), .LVL_PB(lv), .IRQ_SHORT(sh), .INTERRUPT_MASK_LEVEL(mask),
    .EXCEPTION_BLOCK_FLAG(bf), .INSN_END(ie), .NEXT_MASKS(nm), .VECTOR_BASE(vb),
    .SAVE_CTX(save), .FETCH_START(fetch), .HANDLER_ADDR(addr), .BUSY(busy));
  irt_cpu_model cpu_u (.mclk(mclk), .sys_rst(rst), .insn_len(len), .blk_in(blk),
    .masks_in(msk), .insn_end(ie), .blk_flag(bf), .next_masks(nm));
  // seeded lfsr, stepped once per call, keeps the run repeatable
  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction
  task automatic chk(string nm_s, logic [31:0] e, logic [31:0] s);
    checks_done++;
    if (e !== s) begin
      num_errors++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm_s, e, s);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one request; k cycles of hold-off from block or masking flags
  task automatic run(int s, logic short, int d, int k, logic m, logic [2:0] l);
    logic [15:0] r;
    r = rnd();
    len = l;
    sh = short;
    mask = {1'b0, r[2:0]};
    lv = 4'h8 | r[6:4];
    vb = {rnd(), rnd()};
    blk = (k > 0) && !m;
    msk = (k > 0) && m;
    n.lo = (k > 0) ? cyc + k + 1 : cyc + 4 + d;
    n.hi = n.lo + l - 1;
    n.a = vb + HANDLER_OFS;
    q.push_back(n);
    req = NSRC'(1) << s;
    repeat (k) @(negedge mclk);
    blk = 1'b0;
    msk = 1'b0;
    for (int i = 0; i < 60 && fetch !== 1'b1; i++) @(negedge mclk);
    req = '0;
    repeat (3) @(negedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  // outputs settle by the falling edge; every save must match a note
  always @(negedge mclk) begin
    if (fetch === 1'b1 || cyc == fexp) chk("fetch_start", fexp, fetch ? cyc : -1);
    if (fetch === 1'b1) chk("busy_at_fetch", 0, busy);
    if (save === 1'b1) begin
      chk("busy_at_save", 1, busy);
      fexp = cyc + int'(SAVE_CYC);
      if (q.size() == 0) chk("unexpected_save", 0, 1);
      else begin
        n = q.pop_front();
        chk("save_cyc", (cyc >= n.lo && cyc <= n.hi) ? cyc : n.lo, cyc);
        chk("handler_addr", n.a, addr);
      end
    end
  end
  initial begin
    #(20 * 6000);
    num_errors++;
    stop_test();
  end
  initial begin
    int dt[6];
    int sr[6];
    dt = '{DEC_NMI, DEC_IRQ, DEC_IRQS, DEC_PORT_INTERRUPT, DEC_PA, DEC_PB};
    sr = '{0, 1, 1, 2, 3, 4};
    {rst, sh, blk, msk, req, lv, mask, len, vb, cyc, fexp} = '0;
    rst = 1'b1;
    len = 3'h1;
    fexp = -1;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    chk("addr_rst", 0, addr);
    for (int i = 0; i < 6; i++) run(sr[i], i == 2, dt[i], 0, 0, 3'h1);
    run(3, 0, DEC_PA, 0, 0, LONGEST_HIT[2:0]);
    run(0, 0, DEC_NMI, 20, 0, 3'h1);
    run(4, 0, DEC_PB, 20, 1, 3'h1);
    // level equal to the mask must never start a sequence
    mask = 4'h6;
    lv = 4'h6;
    req = 5'h02;
    repeat (30) @(negedge mclk);
    chk("busy_masked", 0, busy);
    req = '0;
    repeat (3) @(negedge mclk);
    chk("notes_left", 0, q.size());
    stop_test();
  end
endmodule
`default_nettype wire
